// ===== core/indicator_lamp_test_sequencer.sv
module indicator_lamp_test_sequencer
  import lamp_test_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [lamp_test_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [lamp_test_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic [lamp_test_pkg::NUM_OPERANDS-1:0] operands,
  input  wire logic                             panel_reset_req,
  input  wire logic                             remote_reset_req,
  output logic [lamp_test_pkg::NUM_LAMPS-1:0]   indicator_on,
  output logic                                  lamp_test_active_flag,
  output logic                                  lamp_test_started_event
);
  import lamp_test_pkg::*;

  // ==========================================================
  // register storage
  logic                   lamp_test_enable_setting_q;
  logic [SEL_W-1:0]       lamp_test_trigger_select_q;
  logic [SEL_W-1:0]       reset_select_q;
  logic [SEL_W-1:0]       src_sel_q [NUM_LAMPS];
  logic [NUM_LAMPS-1:0]   indicator_hold_style_q;
  logic [NUM_LAMPS-1:0]   shadow_state;
  logic [NUM_LAMPS-1:0]   latch_q;
  logic [NUM_LAMPS-1:0]   latch_d;

  // ==========================================================
  // axi4-lite write path
  logic              aw_full_q;
  logic              w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              wr_fire;
  logic              wr_is_ctrl;
  logic              wr_is_cfg;
  logic [IDX_W-1:0]  wr_idx;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_full_q && w_full_q && !bvalid_q;
  assign wr_idx        = awaddr_q[ADDR_IDX_LSB +: IDX_W];
  assign wr_is_ctrl    = (awaddr_q == CTRL_OFS);
  assign wr_is_cfg     = (awaddr_q[ADDR_W-1:ADDR_PAGE_LSB] == CFG_PAGE) &&
                         (wr_idx <= LAST_IDX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      // address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      // status and lamp words are read-only; writes there are refused
      bresp_q  <= (wr_is_ctrl || wr_is_cfg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamp_test_enable_setting_q <= 1'b0;
      lamp_test_trigger_select_q <= SEL_RST;
      reset_select_q             <= SEL_RST;
    end else if (wr_fire && wr_is_ctrl) begin
      if (wstrb_q[0])
        lamp_test_enable_setting_q <= wdata_q[CTRL_EN_BIT];
      if (wstrb_q[1])
        lamp_test_trigger_select_q <= wdata_q[CTRL_TRIG_LSB +: SEL_W];
      if (wstrb_q[2])
        reset_select_q <= wdata_q[CTRL_RST_LSB +: SEL_W];
    end
  end

  // ==========================================================
  // millisecond timebase and sequencer
  test_state_t      state_q;
  test_state_t      state_d;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] idx_d;
  logic [TICK_W-1:0] tick_q;
  logic [MS_W-1:0]  ms_q;
  logic             ms_tick;
  logic             restart;
  logic             step_done;
  logic             trig;
  logic             trig_q;
  logic             trig_rise;
  logic             start;

  assign trig      = operands[lamp_test_trigger_select_q];
  assign trig_rise = trig && !trig_q;
  assign ms_tick   = (tick_q == TICK_W'(CYCLES_PER_MS - 1));
  assign step_done = ms_tick && (ms_q == STEP_MS - 16'h0_001);
  assign start     = (state_q == st_idle) && lamp_test_enable_setting_q &&
                     trig_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      trig_q <= 1'b0;
    else
      trig_q <= trig;
  end

  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    restart = 1'b0;
    case (state_q)
      st_idle: begin
        if (start) begin
          state_d = st_all_on;
          restart = 1'b1;
        end
      end
      st_all_on: begin
        if (!trig) begin
          state_d = st_scan_on;
          idx_d   = '0;
          restart = 1'b1;
        end else if (ms_tick && ms_q == LIMIT_MS - 16'h0_001) begin
          state_d = st_idle;
          restart = 1'b1;
        end
      end
      st_scan_on, st_scan_off: begin
        if (trig_rise) begin
          state_d = st_idle;
          restart = 1'b1;
        end else if (step_done) begin
          restart = 1'b1;
          if (idx_q == LAST_IDX) begin
            idx_d   = '0;
            // scan-on finishing hands over to scan-off
            state_d = (state_q == st_scan_on) ? st_scan_off : st_idle;
          end else begin
            idx_d = idx_q + 6'h0_1;
          end
        end
      end
      default: begin
        state_d = st_idle;
        restart = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= st_idle;
      idx_q   <= '0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
    end
  end

  // tick prescaler restarts too, so each step is a whole second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= '0;
      ms_q   <= '0;
    end else if (restart) begin
      tick_q <= '0;
      ms_q   <= '0;
    end else if (ms_tick) begin
      tick_q <= '0;
      ms_q   <= ms_q + 16'h0_001;
    end else begin
      tick_q <= tick_q + TICK_W'(1);
    end
  end

  // ==========================================================
  // indicator sources, latches and panel drive
  logic                 active;
  logic                 clear_latches;
  logic [NUM_LAMPS-1:0] pattern;
  logic [NUM_LAMPS-1:0] onehot;

  assign active        = (state_q != st_idle);
  // panel reset has no effect mid-test; remote and programmed still do
  assign clear_latches = (panel_reset_req && !active) ||
                         remote_reset_req ||
                         operands[reset_select_q];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LAMPS; gi++) begin : g_lamp
      logic src;
      assign src          = operands[src_sel_q[gi]];
      assign latch_d[gi]  = src || (latch_q[gi] && !clear_latches);
      // trip lamps never latch
      assign shadow_state[gi] =
        (gi >= NUM_TRIP && indicator_hold_style_q[gi]) ?
        latch_q[gi] : src;
      assign onehot[gi] = (idx_d == IDX_W'(gi));

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          src_sel_q[gi]              <= SEL_RST;
          indicator_hold_style_q[gi] <= 1'b0;
        end else if (wr_fire && wr_is_cfg && wr_idx == IDX_W'(gi)) begin
          if (wstrb_q[0])
            src_sel_q[gi] <= wdata_q[SEL_W-1:0];
          if (wstrb_q[1])
            indicator_hold_style_q[gi] <= wdata_q[CFG_STYLE_BIT];
        end
      end
    end
  endgenerate

  // latches keep tracking during a test, so the result survives it
  always_ff @(posedge aclk) begin
    if (!aresetn)
      latch_q <= '0;
    else
      latch_q <= latch_d;
  end

  // lamps follow the state being entered, so lamps and flag move together
  assign pattern = stage_pattern(state_d, onehot);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      indicator_on            <= '0;
      lamp_test_active_flag   <= 1'b0;
      lamp_test_started_event <= 1'b0;
    end else begin
      indicator_on <= (state_d != st_idle) ? pattern :
                      shadow_state;
      lamp_test_active_flag   <= (state_d != st_idle);
      lamp_test_started_event <= start;
    end
  end

  // scan index comes in one-hot, so no index can fall off the end
  function automatic logic [NUM_LAMPS-1:0] stage_pattern(
    input test_state_t          s,
    input logic [NUM_LAMPS-1:0] oh
  );
    case (s)
      st_all_on:   stage_pattern = '1;
      st_scan_on:  stage_pattern = oh;
      st_scan_off: stage_pattern = ~oh;
      default:     stage_pattern = '0;
    endcase
  endfunction : stage_pattern

  // ==========================================================
  // axi4-lite read path
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [IDX_W-1:0] rd_idx;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_idx        = s_axi_araddr[ADDR_IDX_LSB +: IDX_W];

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    if (s_axi_araddr == CTRL_OFS) begin
      rd_word[CTRL_EN_BIT]             = lamp_test_enable_setting_q;
      rd_word[CTRL_TRIG_LSB +: SEL_W]  = lamp_test_trigger_select_q;
      rd_word[CTRL_RST_LSB +: SEL_W]   = reset_select_q;
    end else if (s_axi_araddr == STATUS_OFS) begin
      rd_word[ST_ACTIVE_BIT]           = lamp_test_active_flag;
      rd_word[ST_STAGE_LSB +: ST_STAGE_W] = state_q;
      rd_word[ST_IDX_LSB +: IDX_W]     = idx_q;
    end else if (s_axi_araddr == LAMPS_LO_OFS) begin
      rd_word = indicator_on[31:0];
    end else if (s_axi_araddr == LAMPS_HI_OFS) begin
      rd_word[NUM_LAMPS-33:0] = indicator_on[NUM_LAMPS-1:32];
    end else if (s_axi_araddr[ADDR_W-1:ADDR_PAGE_LSB] == CFG_PAGE &&
                 rd_idx <= LAST_IDX) begin
      rd_word[SEL_W-1:0]    = src_sel_q[rd_idx];
      rd_word[CFG_STYLE_BIT] = indicator_hold_style_q[rd_idx];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : indicator_lamp_test_sequencer

// ===== core/lamp_test_pkg.sv
package lamp_test_pkg;

  // ==========================================================
  // panel geometry and operand selection
  localparam int unsigned NUM_LAMPS     = 62;
  localparam int unsigned NUM_TRIP      = 14;
  localparam int unsigned NUM_GENERAL   = 48;
  localparam int unsigned NUM_OPERANDS  = 64;
  localparam int unsigned SEL_W         = 6;
  localparam int unsigned IDX_W         = 6;
  localparam logic [IDX_W-1:0] LAST_IDX = 6'(NUM_LAMPS - 1);

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NS_PER_MS     = 1_000_000;
  localparam int unsigned CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned STEP_TIME_S   = 1;
  localparam int unsigned LIMIT_TIME_MIN = 1;
  localparam int unsigned MS_W          = 16;
  localparam logic [MS_W-1:0] STEP_MS   = 16'(STEP_TIME_S * 1000);
  localparam logic [MS_W-1:0] LIMIT_MS  = 16'(LIMIT_TIME_MIN * 60_000);
  localparam int unsigned TICK_W        = 20;

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W         = 12;
  localparam logic [11:0] CTRL_OFS       = 12'h0_000;
  localparam logic [11:0] STATUS_OFS     = 12'h0_004;
  localparam logic [11:0] LAMPS_LO_OFS   = 12'h0_008;
  localparam logic [11:0] LAMPS_HI_OFS   = 12'h0_00C;
  localparam logic [3:0]  CFG_PAGE       = 4'h1;
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_TRIG_LSB  = 8;
  localparam int unsigned CTRL_RST_LSB   = 16;
  localparam int unsigned CFG_STYLE_BIT  = 8;
  localparam int unsigned ST_STAGE_LSB   = 1;
  localparam int unsigned ST_IDX_LSB     = 8;
  localparam int unsigned ST_ACTIVE_BIT  = 0;
  localparam int unsigned ST_STAGE_W     = 2;
  localparam int unsigned ADDR_IDX_LSB   = 2;
  localparam int unsigned ADDR_PAGE_LSB  = 8;
  localparam logic [SEL_W-1:0] SEL_RST   = 6'h0_0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    st_idle, st_all_on, st_scan_on, st_scan_off
  } test_state_t;

endpackage : lamp_test_pkg

// ===== tb/lamp_test_monitor.sv
module lamp_test_monitor
  import lamp_test_pkg::*;
(
  input wire logic                                aclk,
  input wire logic                                aresetn,
  input wire logic                                s_axi_awvalid,
  input wire logic                                s_axi_awready,
  input wire logic                                s_axi_wvalid,
  input wire logic                                s_axi_wready,
  input wire logic                                s_axi_bvalid,
  input wire logic                                s_axi_arvalid,
  input wire logic                                s_axi_arready,
  input wire logic                                s_axi_rvalid,
  input wire logic [lamp_test_pkg::NUM_LAMPS-1:0] indicator_on,
  input wire logic                                lamp_test_active_flag,
  input wire logic                                lamp_test_started_event
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // lamp test stages
  sequence stage1_s;
    lamp_test_active_flag && (&indicator_on);
  endsequence
  sequence scan_s;
    lamp_test_active_flag && $onehot(indicator_on);
  endsequence

  start_lamps_a: assert property (
    lamp_test_started_event |-> lamp_test_active_flag && (&indicator_on))
    else $error("start without full panel");
  event_once_a: assert property (
    lamp_test_started_event |=> !lamp_test_started_event)
    else $error("start event longer than one cycle");
  flag_start_a: assert property (
    $rose(lamp_test_active_flag) |-> lamp_test_started_event)
    else $error("test active without start event");
  pattern_ok_a: assert property (
    lamp_test_active_flag |-> (&indicator_on) || $onehot(indicator_on)
      || $onehot(~indicator_on))
    else $error("illegal test pattern");
  first_lamp_a: assert property (
    stage1_s ##1 scan_s |-> indicator_on[0])
    else $error("scan does not start at first lamp");
  scan_step_a: assert property (
    scan_s ##1 (scan_s and indicator_on != $past(indicator_on))
      |-> indicator_on == ($past(indicator_on) << 1))
    else $error("scan skipped a lamp");

  // ==========================================================
  // register bus
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule : lamp_test_monitor

bind indicator_lamp_test_sequencer lamp_test_monitor mon_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .indicator_on, .lamp_test_active_flag,
  .lamp_test_started_event
);

// ===== tb/operand_source.sv
module operand_source
  import lamp_test_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 250
) (
  input  wire logic [lamp_test_pkg::NUM_OPERANDS-1:0] req,
  input  wire logic                                   aclk,
  input  wire logic [lamp_test_pkg::SEL_W-1:0]        trig_sel,
  output logic [lamp_test_pkg::NUM_OPERANDS-1:0]      operands
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned             hold_q;
  logic [NUM_OPERANDS-1:0] stretch;

  // ==========================================================
  // trigger stretch: a short press still lasts the minimum
  assign stretch = (hold_q != 0) ? (NUM_OPERANDS'(1) << trig_sel) : '0;

  always_ff @(posedge aclk) begin
    if (req[trig_sel] && !operands[trig_sel])
      hold_q <= HOLD_CYC - 1;
    else if (hold_q != 0)
      hold_q <= hold_q - 1;
  end

  always_ff @(posedge aclk) begin
    operands <= req | stretch;
  end
endmodule : operand_source

// ===== tb/testbench.sv
module testbench import lamp_test_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CPM = 1;
  logic                    aclk, aresetn, panel_reset_req, remote_reset_req;
  logic [ADDR_W-1:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                    s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                    s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                    s_axi_rready, lamp_test_active_flag;
  logic                    lamp_test_started_event;
  logic [NUM_OPERANDS-1:0] req, operands;
  logic [NUM_LAMPS-1:0]    indicator_on;
  int                      num_errors, checks_done, events;
  logic [NUM_LAMPS-1:0]    lamps_s;
  logic                    flag_s;

  indicator_lamp_test_sequencer #(.CYCLES_PER_MS(CPM)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .operands, .panel_reset_req,
    .remote_reset_req, .indicator_on, .lamp_test_active_flag,
    .lamp_test_started_event
  );
  operand_source #(.HOLD_CYC(250 * CPM)) src_u (
    .req, .aclk, .trig_sel(6'h1), .operands
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // outputs taken mid-cycle, never in the step of their launching edge
  always @(negedge aclk) begin
    lamps_s <= indicator_on;
    flag_s  <= lamp_test_active_flag;
    if (lamp_test_started_event === 1'b1)
      events <= events + 1;
  end
  initial begin
    repeat (80_000) @(posedge aclk);
    num_errors++;
    results();
  end

  // ==========================================================
  // helpers
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_lamp(input logic [61:0] got, input logic [61:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_lamp
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic flag_is(input logic f);
    cmp_word({31'h0, flag_s}, {31'h0, f});
  endtask : flag_is
  // requests held until the edge after ready was seen high mid-cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic pa, pw, got;
    logic [1:0] rsp;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      @(posedge aclk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do begin
      @(negedge aclk);
      got = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
    end while (!got);
    s_axi_bready <= 1'b0;
    cmp_word({30'h0, rsp}, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic got;
    logic [31:0] dat;
    logic [1:0] rsp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      got = s_axi_arready;
      @(posedge aclk);
    end while (!got);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      got = s_axi_rvalid;
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
    end while (!got);
    s_axi_rready <= 1'b0;
    cmp_word(dat, d);
    cmp_word({30'h0, rsp}, {30'h0, r});
  endtask : rd

  // ==========================================================
  // tests
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, panel_reset_req, remote_reset_req} = '0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS, 32'h0, RESP_OKAY);
    rd(12'h7F0, 32'h0, RESP_SLVERR);
    wr(STATUS_OFS, 32'h1, RESP_SLVERR);
    wr(CTRL_OFS, 32'h0002_0101, RESP_OKAY);
    rd(CTRL_OFS, 32'h0002_0101, RESP_OKAY);
    wr(12'h100, 32'h3, RESP_OKAY);
    wr(12'h138, 32'h0104, RESP_OKAY);
    wr(12'h13C, 32'h4, RESP_OKAY);
    req <= 64'h18;
    tick(4);
    cmp_lamp(lamps_s, 62'hC001);
    req <= 64'h8;
    tick(4);
    cmp_lamp(lamps_s, 62'h4001);
    req <= 64'hA;
    tick(4);
    flag_is(1'b1);
    cmp_lamp(lamps_s, '1);
    req <= 64'h2;
    panel_reset_req <= 1'b1;
    tick(300);
    cmp_lamp(lamps_s, '1);
    req <= 64'h0;
    tick(4);
    cmp_lamp(lamps_s, 62'h1);
    rd(STATUS_OFS, 32'h0000_0005, RESP_OKAY);
    rd(LAMPS_LO_OFS, 32'h0000_0001, RESP_OKAY);
    rd(LAMPS_HI_OFS, 32'h0000_0000, RESP_OKAY);
    rd(12'h138, 32'h0000_0104, RESP_OKAY);
    tick(1000 * CPM - 8);
    cmp_lamp(lamps_s, 62'h2);
    panel_reset_req <= 1'b0;
    req <= 64'h2;
    tick(4);
    flag_is(1'b0);
    cmp_lamp(lamps_s, 62'h4000);
    cmp_word(events, 32'h1);
    tick(5);
    flag_is(1'b0);
    req <= 64'h4;
    tick(260);
    cmp_lamp(lamps_s, 62'h0);
    req <= 64'h2;
    tick(59_990 * CPM);
    flag_is(1'b1);
    tick(20 * CPM);
    flag_is(1'b0);
    cmp_word(events, 32'h2);
    req <= 64'h0;
    s_axi_wstrb <= 4'h1;
    wr(CTRL_OFS, 32'h00FF_FF00, RESP_OKAY);
    rd(CTRL_OFS, 32'h0002_0100, RESP_OKAY);
    req <= 64'h2;
    tick(6);
    flag_is(1'b0);
    results();
  end
endmodule : testbench
